// file: hdl/ckd_ctrl.sv
`timescale 1ns/1ps
// Clock path control: power-down, configuration load, smart mux and dividers

// Contract
// - Power-down pin low holds device in reset
// - Pin rising with latch enable high reloads nonvolatile configuration into RAM
// - Shadow bit enters power-down; release skips reload
// - Reference divider code decodes to ratios 1..16
// - Automatic mux prefers usable primary reference
// - External feedback routes auxiliary straight to detector
// - Two output channels with own divider codes
// - Output codes decode; three codes disable output
// - Input divider feeds detector from selected clock
// - Factory configuration loads automatic switching defaults
// - One-zero-one sync bit restarts both outputs together
module ckd_ctrl (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic power_down_pin_in,
    input wire logic serial_latch_enable_in,
    input wire logic ref_clk_in,
    input wire logic aux_ref_input_in,
    input wire logic clock_a_in,
    input wire logic pd_bit_in,
    input wire logic sync_bit_in,
    input wire logic ram_wr_in,
    input wire logic ram_addr_in,
    input wire logic [ckd_pkg::RAM_W-1:0] ram_wdata_in,
    input wire logic nvm_store_in,
    output logic [ckd_pkg::RAM_W-1:0] ram0_out,
    output logic [ckd_pkg::RAM_W-1:0] ram1_out,
    output logic pwr_down_out,
    output logic active_out,
    output logic ram_loaded_out,
    output logic sel_aux_out,
    output logic ext_fb_out,
    output logic pfd_ref_out,
    output logic pfd_fb_out,
    output logic out0_en_out,
    output logic out1_en_out,
    output logic out0_tick_out,
    output logic out1_tick_out
);
    import ckd_pkg::*;

    ckd_ctl_t q; // Registered control state
    ckd_ctl_t n; // Next control state
    logic [PIN_N-1:0] agree; // Second and third sampler stages agree
    logic [PIN_N-1:0] rise; // Accepted rising edge per pin
    logic running; // Reference path enabled
    logic ref_present; // Divided reference seen recently
    logic aux_present; // Auxiliary input seen recently
    logic [3:0] out0_code; // Output 0 divider code
    logic [3:0] out1_code; // Output 1 divider code

    ckd_div_if i_ref (); // Reference divider
    ckd_div_if i_in (); // Input divider
    ckd_div_if i_o0 (); // Output 0 divider
    ckd_div_if i_o1 (); // Output 1 divider

    assign running = q.pwr == CKD_ACTIVE || q.pwr == CKD_SYNC;
    assign out0_code = q.ram0[OUT0_LSB +: 4];
    assign out1_code = q.ram0[OUT1_LSB +: 4];

    // Next state: pin sampling, power sequencing, RAM and mux
    always_comb begin
        n = q;
        // Three-stage pin samplers, a level counts once stages two and three agree
        n.sy1 = {clock_a_in, aux_ref_input_in, ref_clk_in, serial_latch_enable_in, power_down_pin_in};
        n.sy2 = q.sy1;
        n.sy3 = q.sy2;
        agree = ~(q.sy2 ^ q.sy3);
        n.lvl = (agree & q.sy3) | (~agree & q.lvl);
        rise = n.lvl & ~q.lvl;
        n.load_pulse = 1'b0;
        n.sync_prev = sync_bit_in;
        // Any time the pin is low, a release with latch enable high is followed by a reload
        if (!q.lvl[PIN_PD]) begin
            n.load_pend = 1'b1;
        end
        case (q.pwr)
            // Powered down: dividers and monitors stopped; host RAM writes and the mux select still update
            CKD_DOWN: begin
                n.le_ok = q.lvl[PIN_LE];
                if (q.lvl[PIN_PD] && pd_bit_in) begin
                    n.pwr = q.load_pend ? CKD_LOAD : CKD_ACTIVE;
                end
            end
            // Copy the nonvolatile image into RAM
            CKD_LOAD: begin
                if (!q.lvl[PIN_PD] || !pd_bit_in) begin
                    n.pwr = CKD_DOWN;
                end else begin
                    n.pwr = CKD_ACTIVE;
                    n.load_pend = 1'b0;
                    if (q.le_ok) begin
                        n.ram0 = q.nvm0;
                        n.ram1 = q.nvm1;
                        n.load_pulse = 1'b1;
                    end
                end
            end
            // Normal operation
            CKD_ACTIVE: begin
                if (!q.lvl[PIN_PD] || !pd_bit_in) begin
                    n.pwr = CKD_DOWN;
                end else if (q.sync_prev && !sync_bit_in) begin
                    n.pwr = CKD_SYNC;
                end
            end
            // Output dividers held until the sync bit returns high
            CKD_SYNC: begin
                if (!q.lvl[PIN_PD] || !pd_bit_in) begin
                    n.pwr = CKD_DOWN;
                end else if (sync_bit_in) begin
                    n.pwr = CKD_ACTIVE;
                end
            end
            default: begin
                n.pwr = CKD_DOWN;
            end
        endcase
        // Host writes to RAM, the load takes priority
        if (ram_wr_in && q.pwr != CKD_LOAD) begin
            if (ram_addr_in) begin
                n.ram1 = ram_wdata_in;
            end else begin
                n.ram0 = ram_wdata_in;
            end
        end
        // Store working registers into the nonvolatile image
        if (nvm_store_in) begin
            n.nvm0 = q.ram0;
            n.nvm1 = q.ram1;
        end
        // Mux: automatic mode prefers the reference while it is present
        if (q.ram1[AUTO_SEL_BIT]) begin
            n.sel_aux = !ref_present && aux_present;
        end else begin
            n.sel_aux = q.ram1[MAN_AUX_BIT];
        end
        // External feedback passes auxiliary edges straight on
        n.pfd_fb = ext_fb_out && running && rise[PIN_AUX];
    end

    // State register
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= CTL_RST;
        end else begin
            q <= n;
        end
    end

    // Reference divider on the primary input
    assign i_ref.tick = rise[PIN_REF];
    assign i_ref.run = running;
    assign i_ref.restart = 1'b0;
    assign i_ref.ratio = ckd_ref_ratio(q.ram0[REF_DIV_LSB +: 4]);

    // Input divider on the clock chosen by the mux
    assign i_in.tick = q.sel_aux ? rise[PIN_AUX] : i_ref.pulse;
    assign i_in.run = running;
    assign i_in.restart = 1'b0;
    assign i_in.ratio = {1'b0, q.ram1[IN_DIV_LSB +: 8]} + 9'h001;

    // Output channels, both restarted together while syncing
    assign i_o0.tick = rise[PIN_SYN];
    assign i_o0.run = running;
    assign i_o0.restart = q.pwr == CKD_SYNC;
    assign i_o0.ratio = ckd_out_ratio(out0_code);
    assign i_o1.tick = rise[PIN_SYN];
    assign i_o1.run = running;
    assign i_o1.restart = q.pwr == CKD_SYNC;
    assign i_o1.ratio = ckd_out_ratio(out1_code);

    ckd_divider u_ref (.mclk_in(mclk_in), .nrst_in(nrst_in), .dv(i_ref));
    ckd_divider u_in (.mclk_in(mclk_in), .nrst_in(nrst_in), .dv(i_in));
    ckd_divider u_o0 (.mclk_in(mclk_in), .nrst_in(nrst_in), .dv(i_o0));
    ckd_divider u_o1 (.mclk_in(mclk_in), .nrst_in(nrst_in), .dv(i_o1));

    // Presence monitors, each input judged against edges of the other
    ckd_monitor u_ref_mon (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .run_in(running),
        .mon_ev_in(i_ref.pulse),
        .other_ev_in(rise[PIN_AUX]),
        .present_out(ref_present)
    );
    ckd_monitor u_aux_mon (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .run_in(running),
        .mon_ev_in(rise[PIN_AUX]),
        .other_ev_in(i_ref.pulse),
        .present_out(aux_present)
    );

    // Outputs
    assign ram0_out = q.ram0;
    assign ram1_out = q.ram1;
    assign pwr_down_out = q.pwr == CKD_DOWN;
    assign active_out = q.pwr == CKD_ACTIVE;
    assign ram_loaded_out = q.load_pulse;
    assign sel_aux_out = q.sel_aux;
    assign ext_fb_out = q.ram0[EXT_FB_BIT] && !q.sel_aux;
    assign pfd_ref_out = i_in.pulse;
    assign pfd_fb_out = q.pfd_fb;
    assign out0_en_out = active_out && i_o0.ratio != 9'h000;
    assign out1_en_out = active_out && i_o1.ratio != 9'h000;
    assign out0_tick_out = i_o0.pulse;
    assign out1_tick_out = i_o1.pulse;

    // Pin release with latch enable high and shadow bit set
    sequence s_pin_release;
        $rose(q.lvl[PIN_PD]) && pd_bit_in && q.lvl[PIN_LE] ##1 q.lvl[PIN_PD] && pd_bit_in;
    endsequence

    // Shadow release with no reload pending
    sequence s_shadow_release;
        q.pwr == CKD_DOWN && !q.load_pend && q.lvl[PIN_PD] && pd_bit_in;
    endsequence

    // Sync bit falls during normal operation
    sequence s_sync_fall;
        active_out && q.lvl[PIN_PD] && pd_bit_in && q.sync_prev && !sync_bit_in;
    endsequence

    pin_down_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        !q.lvl[PIN_PD] |=> pwr_down_out && !out0_en_out && !out1_en_out)
        else $error("pin low did not power down");

    pin_reload_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        s_pin_release |=> ram_loaded_out && ram0_out == $past(q.nvm0))
        else $error("pin release did not reload RAM");

    shadow_enter_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        !pd_bit_in |=> pwr_down_out)
        else $error("shadow bit did not power down");

    shadow_no_load_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        s_shadow_release |=> active_out ##1 !ram_loaded_out)
        else $error("shadow release reloaded RAM");

    mux_prefers_ref_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        q.ram1[AUTO_SEL_BIT] && ref_present |=> !sel_aux_out)
        else $error("auto mux left the present reference");

    ext_fb_route_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        ext_fb_out && running && rise[PIN_AUX] |=> pfd_fb_out)
        else $error("auxiliary edge not routed to detector");

    out_disable_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        out0_code == 4'h0 || out0_code == 4'h7 || out0_code == 4'h9 |-> !out0_en_out)
        else $error("disabled code left output 0 on");

    sync_restart_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        // A pulse launched on the falling edge itself may still show; the restart clears the next one
        s_sync_fall |=> !out0_en_out && !out1_en_out ##1 !out0_tick_out && !out1_tick_out)
        else $error("sync did not stop both outputs");
endmodule : ckd_ctrl

// file: hdl/ckd_pkg.sv
// Constants, types and decode functions for the clock divider and mux control
package ckd_pkg;
    localparam int RAM_W = 28; // Width of one working register
    localparam int REF_DIV_LSB = 6; // Reference divider code, register 0
    localparam int EXT_FB_BIT = 10; // External feedback enable, register 0
    localparam int OUT0_LSB = 15; // Output 0 divider code, register 0
    localparam int OUT1_LSB = 19; // Output 1 divider code, register 0
    localparam int IN_DIV_LSB = 1; // Input divider code, register 1
    localparam int AUTO_SEL_BIT = 9; // Automatic mux selection, register 1
    localparam int MAN_AUX_BIT = 10; // Manual mux choice of auxiliary, register 1
    localparam logic [RAM_W-1:0] NVM0_RST = 28'h02A0000; // Factory register 0
    localparam logic [RAM_W-1:0] NVM1_RST = 28'h0000206; // Factory register 1
    localparam logic [3:0] LOSS_EDGES = 4'h8; // Foreign edges before an input counts as absent
    localparam int PIN_N = 5; // Number of sampled pins
    localparam int PIN_PD = 0; // Power-down pin slot
    localparam int PIN_LE = 1; // Serial latch enable slot
    localparam int PIN_REF = 2; // Primary reference slot
    localparam int PIN_AUX = 3; // Auxiliary input slot
    localparam int PIN_SYN = 4; // Synthesizer clock slot

    // Power and sequencing states
    typedef enum logic [1:0] {CKD_DOWN, CKD_LOAD, CKD_ACTIVE, CKD_SYNC} ckd_pwr_t;

    // Whole control state of the top module
    typedef struct packed {
        logic [PIN_N-1:0] sy1;
        logic [PIN_N-1:0] sy2;
        logic [PIN_N-1:0] sy3;
        logic [PIN_N-1:0] lvl;
        ckd_pwr_t pwr;
        logic [RAM_W-1:0] ram0;
        logic [RAM_W-1:0] ram1;
        logic [RAM_W-1:0] nvm0;
        logic [RAM_W-1:0] nvm1;
        logic load_pend;
        logic le_ok;
        logic load_pulse;
        logic sync_prev;
        logic sel_aux;
        logic pfd_fb;
    } ckd_ctl_t;

    // Reset image: powered down with a load pending, as at power-up
    localparam ckd_ctl_t CTL_RST = '{sy1: '0, sy2: '0, sy3: '0, lvl: '0, pwr: CKD_DOWN,
        ram0: '0, ram1: '0, nvm0: NVM0_RST, nvm1: NVM1_RST, load_pend: 1'b1, le_ok: 1'b1,
        load_pulse: 1'b0, sync_prev: 1'b1, sel_aux: 1'b0, pfd_fb: 1'b0};

    // Reference divider code to ratio
    function automatic logic [8:0] ckd_ref_ratio(input logic [3:0] code);
        if (code[3]) begin
            ckd_ref_ratio = {5'h00, code[2:0], 1'b0} + 9'h002;
        end else begin
            ckd_ref_ratio = {5'h00, code} + 9'h001;
        end
    endfunction : ckd_ref_ratio

    // Output divider code to ratio, zero means disabled
    function automatic logic [8:0] ckd_out_ratio(input logic [3:0] code);
        case (code)
            4'h1: ckd_out_ratio = 9'h001;
            4'h2: ckd_out_ratio = 9'h002;
            4'h3: ckd_out_ratio = 9'h003;
            4'h4: ckd_out_ratio = 9'h004;
            4'h5: ckd_out_ratio = 9'h005;
            4'h6: ckd_out_ratio = 9'h006;
            4'h8: ckd_out_ratio = 9'h008;
            4'hA: ckd_out_ratio = 9'h00A;
            4'hB: ckd_out_ratio = 9'h014;
            4'hC: ckd_out_ratio = 9'h00C;
            4'hD: ckd_out_ratio = 9'h018;
            4'hE: ckd_out_ratio = 9'h010;
            4'hF: ckd_out_ratio = 9'h020;
            default: ckd_out_ratio = 9'h000;
        endcase
    endfunction : ckd_out_ratio
endpackage : ckd_pkg

// file: hdl/ckd_div_if.sv
`timescale 1ns/1ps
// Link between the control and one counting divider
interface ckd_div_if;
    logic tick; // Source edge, one cycle
    logic run; // Divider allowed to count
    logic restart; // Hold count at zero
    logic [8:0] ratio; // Divide ratio, zero stops it
    logic pulse; // One pulse per ratio source edges
    modport ctrl (output tick, output run, output restart, output ratio, input pulse);
    modport div (input tick, input run, input restart, input ratio, output pulse);
endinterface : ckd_div_if

// file: hdl/ckd_divider.sv
`timescale 1ns/1ps
// Counting divider: one output pulse for each ratio source edges
module ckd_divider (
    input wire logic mclk_in,
    input wire logic nrst_in,
    ckd_div_if.div dv
);
    import ckd_pkg::*;

    // Counter state
    typedef struct packed {
        logic [8:0] cnt;
        logic pulse;
    } ckd_div_st_t;

    ckd_div_st_t q; // Registered state
    ckd_div_st_t n; // Next state

    // Count source edges and wrap at the ratio
    always_comb begin
        n = q;
        n.pulse = 1'b0;
        if (!dv.run || dv.restart || dv.ratio == 9'h000) begin
            n.cnt = 9'h000;
        end else if (dv.tick) begin
            // A ratio lowered mid-count wraps at once rather than running past 511
            if (q.cnt >= dv.ratio - 9'h001) begin
                n.cnt = 9'h000;
                n.pulse = 1'b1;
            end else begin
                n.cnt = q.cnt + 9'h001;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign dv.pulse = q.pulse;

    div_count_end_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        dv.run && !dv.restart && dv.ratio != 9'h000 && dv.tick && q.cnt == dv.ratio - 9'h001 |=> dv.pulse)
        else $error("divider missed its terminal count");

    div_hold_zero_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        dv.restart |=> q.cnt == 9'h000 && !dv.pulse)
        else $error("divider counted while restarted");
endmodule : ckd_divider

// file: hdl/ckd_monitor.sv
`timescale 1ns/1ps
// Activity monitor: an input is absent after enough edges of the other
module ckd_monitor (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic run_in,
    input wire logic mon_ev_in,
    input wire logic other_ev_in,
    output logic present_out
);
    import ckd_pkg::*;

    // Monitor state
    typedef struct packed {
        logic [3:0] cnt;
        logic present;
    } ckd_mon_st_t;

    ckd_mon_st_t q; // Registered state
    ckd_mon_st_t n; // Next state

    // Own edge clears the count, foreign edges advance it
    always_comb begin
        n = q;
        if (!run_in) begin
            n.cnt = 4'h0;
            n.present = 1'b1;
        end else if (mon_ev_in) begin
            n.cnt = 4'h0;
            n.present = 1'b1;
        end else if (other_ev_in) begin
            if (q.cnt == LOSS_EDGES - 4'h1) begin
                n.present = 1'b0;
            end else begin
                n.cnt = q.cnt + 4'h1;
            end
        end
    end

    // State register; inputs start out presumed present
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '{cnt: 4'h0, present: 1'b1};
        end else begin
            q <= n;
        end
    end

    assign present_out = q.present;

    mon_loss_a: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        run_in && !mon_ev_in && other_ev_in && q.cnt == LOSS_EDGES - 4'h1 |=> !present_out)
        else $error("missing input not declared absent");
endmodule : ckd_monitor

// file: test/ckd_src_model.sv
// Clock sources on the far side: primary reference, auxiliary input, synthesizer clock
`timescale 1ns/1ps
module ckd_src_model #(parameter int HALF = 3) (
    input wire logic mclk_in,
    input wire logic ref_on_in,
    input wire logic aux_on_in,
    output logic ref_clk_out,
    output logic aux_out,
    output logic clka_out
);
    int cnt = 0; // Half-period counter in system clocks

    // Auxiliary runs from time zero, so it is present before any release
    initial begin
        clka_out = 1'b0;
        ref_clk_out = 1'b0;
        aux_out = 1'b0;
    end

    // Equal rates on both inputs; a source that is off is grounded
    always @(posedge mclk_in) begin
        #1;
        cnt = (cnt + 1) % HALF;
        if (cnt == 0) begin
            clka_out = ~clka_out;
            ref_clk_out = ref_on_in & clka_out;
            aux_out = aux_on_in & clka_out;
        end
    end
endmodule : ckd_src_model

// file: test/test_ckd_ctrl.sv
// Self-checking bench for the clock divider and mux control
`timescale 1ns/1ps
module test_ckd_ctrl;
    import ckd_pkg::*;
    logic mclk = 1'b0; // System clock
    logic nrst_n, pd_pin, le, pd_bit, sync_bit, wr_s, addr, store, ref_on, aux_on; // Driven inputs
    logic [RAM_W-1:0] wdata, ram0, ram1, v; // Write data, registers, scratch
    logic refc, auxc, clka, pwr_dn, act, loaded, sel_aux, ext_fb, pfd_ref, pfd_fb, en0, en1, t0, t1;
    int bad_count, checks_done, n, d; // Counters and scratch
    // Output divider ratios by code, zero for disabled
    localparam int OUT_R [16] = '{0, 1, 2, 3, 4, 5, 6, 0, 8, 0, 10, 20, 12, 24, 16, 32};

    always #12.5 mclk = ~mclk;

    ckd_src_model src_u (.mclk_in(mclk), .ref_on_in(ref_on), .aux_on_in(aux_on), .ref_clk_out(refc),
        .aux_out(auxc), .clka_out(clka));

    ckd_ctrl dut_u (.mclk_in(mclk), .nrst_in(nrst_n), .power_down_pin_in(pd_pin),
        .serial_latch_enable_in(le), .ref_clk_in(refc), .aux_ref_input_in(auxc), .clock_a_in(clka),
        .pd_bit_in(pd_bit), .sync_bit_in(sync_bit), .ram_wr_in(wr_s), .ram_addr_in(addr),
        .ram_wdata_in(wdata), .nvm_store_in(store), .ram0_out(ram0), .ram1_out(ram1),
        .pwr_down_out(pwr_dn), .active_out(act), .ram_loaded_out(loaded), .sel_aux_out(sel_aux),
        .ext_fb_out(ext_fb), .pfd_ref_out(pfd_ref), .pfd_fb_out(pfd_fb), .out0_en_out(en0),
        .out1_en_out(en1), .out0_tick_out(t0), .out1_tick_out(t1));

    // Compare and count
    task automatic chk(input logic [RAM_W-1:0] seen, input logic [RAM_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Counts, verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Move to the drive and sample point after k edges
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask : step

    // Selected observed signal
    function automatic logic sig(input int w);
        case (w)
            0: return loaded;
            1: return pfd_ref;
            2: return t0;
            3: return t1;
            4: return sel_aux;
            5: return pfd_fb;
            6: return pwr_dn;
            7: return act;
            8: return refc;
            9: return auxc;
            default: return clka;
        endcase
    endfunction : sig

    // Bounded wait for a level
    task automatic wait_for(input int w, input logic lv, input int lim);
        int i;
        for (i = 0; i < lim && sig(w) !== lv; i++) step(1);
        if (i == lim) begin
            bad_count++;
            $display("unexpected at %0t: wait on %0d ran out", $time, w);
            end_of_test();
        end
    endtask : wait_for

    // Source rises between two pulses of w
    task automatic span(input int w, input int src, output int cnt);
        logic p;
        int k;
        wait_for(w, 1'b1, 4000);
        cnt = 0;
        k = 0;
        p = sig(src);
        // Bounded in edges, so a silent source cannot hang the run
        do begin
            step(1);
            k++;
            cnt += int'(sig(src) && !p);
            p = sig(src);
        end while (sig(w) !== 1'b1 && k < 4000);
        if (k == 4000) begin
            bad_count++;
            $display("unexpected at %0t: span on %0d ran out", $time, w);
            end_of_test();
        end
    endtask : span

    // One register write
    task automatic wr(input logic a, input logic [RAM_W-1:0] dat);
        wr_s = 1'b1;
        addr = a;
        wdata = dat;
        step(1);
        wr_s = 1'b0;
        // Let one edge pass so a following write never reassigns the strobe in the same time step
        step(1);
    endtask : wr

    // Register images
    function automatic logic [RAM_W-1:0] r0(input logic [3:0] rd, input logic fb, input logic [3:0] o0,
        input logic [3:0] o1);
        return {5'h00, o1, o0, 4'h0, fb, rd, 6'h00};
    endfunction : r0
    function automatic logic [RAM_W-1:0] r1(input logic aux, input logic auto, input logic [7:0] dv);
        return {17'h00000, aux, auto, dv, 1'b0};
    endfunction : r1
    function automatic int ref_ratio(input logic [3:0] c);
        return c[3] ? 2 * (int'(c[2:0]) + 1) : int'(c) + 1;
    endfunction : ref_ratio

    // Main sequence
    initial begin
        {pd_pin, le, pd_bit, sync_bit, ref_on, aux_on} = 6'h3F;
        {nrst_n, wr_s, addr, store} = 4'h0;
        wdata = '0;
        bad_count = 0;
        checks_done = 0;
        void'($urandom(76));
        repeat (12) @(posedge mclk);
        #2;
        nrst_n = 1'b1;
        // Power-up load of the factory image
        wait_for(0, 1'b1, 100);
        chk(ram0, NVM0_RST);
        chk(ram1, NVM1_RST);
        chk(ram1[AUTO_SEL_BIT], 1'b1);
        chk(act, 1'b1);
        $display("power-up done");
        // Shadow bit: down and back without reload
        v = RAM_W'($urandom());
        wr(1'b0, v);
        pd_bit = 1'b0;
        wait_for(6, 1'b1, 20);
        chk(act, 1'b0);
        pd_bit = 1'b1;
        wait_for(7, 1'b1, 20);
        chk(ram0, v);
        $display("shadow bit done");
        // Pin cycle reloads the stored image
        v = RAM_W'($urandom());
        wr(1'b0, v);
        store = 1'b1;
        step(1);
        store = 1'b0;
        pd_pin = 1'b0;
        wait_for(6, 1'b1, 20);
        chk({act, en0, en1}, 3'h0);
        pd_pin = 1'b1;
        wait_for(0, 1'b1, 50);
        chk(ram0, v);
        // Latch enable low at release: no load, the host value survives
        v = ~v;
        wr(1'b0, v);
        le = 1'b0;
        pd_pin = 1'b0;
        wait_for(6, 1'b1, 20);
        pd_pin = 1'b1;
        wait_for(7, 1'b1, 50);
        chk(loaded, 1'b0);
        chk(ram0, v);
        le = 1'b1;
        $display("power pin done");
        // Output codes: enable and ratio on both channels
        for (int c = 0; c < 16; c++) begin
            wr(1'b0, r0(4'h0, 1'b0, 4'(c), 4'(15 - c)));
            step(2);
            chk(en0, OUT_R[c] != 0);
            chk(en1, OUT_R[15 - c] != 0);
            if (OUT_R[c] != 0) begin
                span(2, 10, n);
                chk(n, OUT_R[c]);
            end
            if (OUT_R[15 - c] != 0) begin
                span(3, 10, n);
                chk(n, OUT_R[15 - c]);
            end
        end
        $display("output codes done");
        // Resync: outputs off in between, then counting together
        wr(1'b0, r0(4'h0, 1'b0, 4'h3, 4'h6));
        step(20);
        sync_bit = 1'b0;
        step(6);
        chk({en0, en1}, 2'h0);
        sync_bit = 1'b1;
        repeat (3) begin
            wait_for(3, 1'b1, 200);
            chk(t0, 1'b1);
            step(1);
        end
        $display("resync done");
        // Reference and input divider on the primary reference
        for (int c = 0; c < 16; c++) begin
            d = $urandom_range(3, 0);
            wr(1'b0, r0(4'(c), 1'b0, 4'h4, 4'h5));
            wr(1'b1, r1(1'b0, 1'b0, 8'(d)));
            span(1, 8, n);
            chk(n, ref_ratio(4'(c)) * (d + 1));
        end
        $display("reference divider done");
        // Automatic mux prefers the reference and drops a silent input
        wr(1'b0, r0(4'h0, 1'b0, 4'h4, 4'h5));
        wr(1'b1, r1(1'b0, 1'b1, 8'h00));
        step(100);
        chk(sel_aux, 1'b0);
        ref_on = 1'b0;
        wait_for(4, 1'b1, 200);
        ref_on = 1'b1;
        wait_for(4, 1'b0, 200);
        aux_on = 1'b0;
        step(200);
        chk(sel_aux, 1'b0);
        aux_on = 1'b1;
        $display("auto mux done");
        // External feedback with both ratios one
        wr(1'b1, r1(1'b0, 1'b0, 8'h00));
        wr(1'b0, r0(4'h0, 1'b1, 4'h4, 4'h5));
        step(3);
        chk(ext_fb, 1'b1);
        span(5, 9, n);
        chk(n, 1);
        wr(1'b1, r1(1'b1, 1'b0, 8'h00));
        step(3);
        chk({ext_fb, sel_aux}, 2'h1);
        $display("external feedback done");
        end_of_test();
    end
endmodule : test_ckd_ctrl
